/* src/ppc_pkg.sv */
// Purpose: shared constants and types of the parallel port control block
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are the printed register offsets
package ppc_pkg;
  localparam logic [11:0] PPC_OFS_TIMING  = 12'hf5c;
  localparam logic [11:0] PPC_OFS_MODE    = 12'hf5d;
  localparam logic [11:0] PPC_OFS_POLAR   = 12'hf5e;
  localparam logic [11:0] PPC_OFS_MAIN    = 12'hf5f;
  localparam logic [11:0] PPC_OFS_ADDRL   = 12'hf60;
  localparam logic [11:0] PPC_OFS_ADDRH   = 12'hf61;
  localparam logic [11:0] PPC_OFS_DATAL   = 12'hf62;
  localparam logic [11:0] PPC_OFS_DATAH   = 12'hf63;
  localparam logic [7:0]  PPC_RST_REG     = 8'h00;
  // main control bit positions
  localparam int PPC_B_PORT_ON    = 7;
  localparam int PPC_B_MUX_HI     = 4;
  localparam int PPC_B_MUX_LO     = 3;
  localparam int PPC_B_BE_PIN     = 2;
  localparam int PPC_B_WR_PIN     = 1;
  localparam int PPC_B_RD_PIN     = 0;
  // polarity bit positions
  localparam int PPC_B_CSF_HI     = 7;
  localparam int PPC_B_CSF_LO     = 6;
  localparam int PPC_B_LATCH_POL  = 5;
  localparam int PPC_B_CS_POL     = 3;
  localparam int PPC_B_BE_POL     = 2;
  localparam int PPC_B_WR_POL     = 1;
  localparam int PPC_B_RD_POL     = 0;
  // mode bit positions
  localparam int PPC_B_BUSY       = 7;
  localparam int PPC_B_IRQ_HI     = 6;
  localparam int PPC_B_INC_HI     = 4;
  localparam int PPC_B_WIDTH16    = 2;
  localparam int PPC_B_MODE_HI    = 1;
  // timing bit positions
  localparam int PPC_B_SETUP_HI   = 7;
  localparam int PPC_B_STROBE_HI  = 5;
  localparam int PPC_B_HOLD_HI    = 1;
  // one instruction cycle at 10 MHz is one clock
  localparam int PPC_TCY_NS       = 100;
  localparam int PPC_CLK_NS       = 100;
  localparam logic [4:0] PPC_TCY_CYC = 5'(PPC_TCY_NS / PPC_CLK_NS);

  typedef enum logic [1:0] {
    PPC_MUX_NONE, PPC_MUX_LOW, PPC_MUX_FULL, PPC_MUX_RSVD
  } ppc_mux_t;
  typedef enum logic [1:0] {
    PPC_MODE_LEGACY, PPC_MODE_ADDR_SLAVE, PPC_MODE_MASTER2, PPC_MODE_MASTER1
  } ppc_mode_t;
  localparam logic [1:0] PPC_CSF_ON    = 2'h2;
  localparam logic [1:0] PPC_IRQ_BUFF3 = 2'h3;
  localparam logic [1:0] PPC_IRQ_STALL = 2'h2;
  localparam logic [1:0] PPC_IRQ_END   = 2'h1;
  localparam logic [1:0] PPC_INC_UP    = 2'h1;
  localparam logic [1:0] PPC_INC_DOWN  = 2'h2;
  localparam logic [1:0] PPC_INC_BUF   = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] dataOut;
    logic       dataOe;
    logic       latchLow;
    logic       latchHigh;
    logic       chipSelect;
    logic       byteEnable;
    logic       readStrobe;
    logic       writeStrobe;
  } ppc_pins_t;
endpackage

/* src/ppc_wait_counter.sv */
// Purpose: loadable down counter for wait phases
// Assumes: load and run never meet an idle counter
// Notes: done is high in the last cycle of the loaded count
`timescale 1ns/1ps
module ppc_wait_counter #(
  parameter int W = 5
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_reg;
  logic         run_reg;
  wire          lastTick = run_reg && (cnt_reg == W'(1));

  // not registered: a count of n must hold a phase for exactly n clocks
  assign done = lastTick;

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      if (load) begin
        cnt_reg <= count;
        run_reg <= 1'b1;
      end else if (lastTick) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end
endmodule // ppc_wait_counter

/* src/ppc_port_control.sv */
// Purpose: control, mode and master timing of an 8-bit parallel port
// Assumes: one clock per instruction cycle, external master keeps slave
//          protocol in slave modes
// Notes: pin enables gate the strobe pins; reads of data start a cycle
`timescale 1ns/1ps
module ppc_port_control
  import ppc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic [7:0]  dataIn,
  input  wire logic        slaveAccess,
  input  wire logic [1:0]  slaveAddr,
  input  wire logic        slaveBufThree,
  output ppc_pins_t        pins,
  output logic             irqPulse,
  output logic             cpuStall
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR_LO, ST_ADDR_HI, ST_SETUP, ST_STROBE, ST_HOLD
  } ppc_state_t;

  logic [7:0]  timing_reg, mode_reg, polar_reg, main_reg;
  logic [15:0] addr_reg, addr_next, data_reg;
  logic        busy_reg, second_reg, isRead_reg;
  ppc_state_t  state_reg, state_next;
  ppc_pins_t   pins_next;
  logic        cntLoad;
  logic [4:0]  cntValue;
  logic        cntDone;

  wire portOn     = main_reg[PPC_B_PORT_ON];
  wire ppc_mux_t muxSel = ppc_mux_t'(main_reg[PPC_B_MUX_HI:PPC_B_MUX_LO]);
  wire ppc_mode_t mode  = ppc_mode_t'(mode_reg[PPC_B_MODE_HI -: 2]);
  wire isMaster   = (mode == PPC_MODE_MASTER1) || (mode == PPC_MODE_MASTER2);
  wire [1:0] chip_select_function  = polar_reg[PPC_B_CSF_HI:PPC_B_CSF_LO];
  wire csOn       = (chip_select_function == PPC_CSF_ON);
  wire [1:0] irqMode = mode_reg[PPC_B_IRQ_HI -: 2];
  wire [1:0] incMode = mode_reg[PPC_B_INC_HI -: 2];
  wire wide       = mode_reg[PPC_B_WIDTH16];
  wire [3:0] strobeWait = timing_reg[PPC_B_STROBE_HI -: 4];
  wire fastOp     = (strobeWait == 4'h0);
  wire [4:0] setupCyc = 5'(timing_reg[PPC_B_SETUP_HI -: 2]) + 5'h1;
  wire [4:0] holdCyc  = 5'(timing_reg[PPC_B_HOLD_HI -: 2]) + 5'h1;
  wire [4:0] strobeCyc = 5'(strobeWait) + PPC_TCY_CYC;

  wire selTiming = regAddr == PPC_OFS_TIMING;
  wire selMode   = regAddr == PPC_OFS_MODE;
  wire selPolar  = regAddr == PPC_OFS_POLAR;
  wire selMain   = regAddr == PPC_OFS_MAIN;
  wire selAddrL  = regAddr == PPC_OFS_ADDRL;
  wire selAddrH  = regAddr == PPC_OFS_ADDRH;
  wire selDataL  = regAddr == PPC_OFS_DATAL;
  wire selDataH  = regAddr == PPC_OFS_DATAH;
  // a data access starts a transfer; high byte with width bit, low otherwise
  wire dataHit   = wide ? selDataH : selDataL;
  wire startXfer = portOn && isMaster && !busy_reg &&
                   (regWrite || regRead) && dataHit;
  wire cfgWrite  = regWrite && !busy_reg;

  wire [7:0] rdMux =
    selTiming ? timing_reg :
    selMode   ? {busy_reg, mode_reg[6:0]} :
    selPolar  ? {polar_reg[7:5], 1'b0, polar_reg[3:0]} :
    selMain   ? {main_reg[7], 2'b00, main_reg[4:0]} :
    selAddrL  ? addr_reg[7:0] :
    selAddrH  ? addr_reg[15:8] :
    selDataL  ? data_reg[7:0] :
    selDataH  ? data_reg[15:8] : 8'h00;

  // address step skips bit 14, which doubles as chip select
  wire [14:0] addrPacked = {addr_reg[15], addr_reg[13:0]};
  wire [14:0] addrUp     = addrPacked + 15'h1;
  wire [14:0] addrDown   = addrPacked - 15'h1;
  wire lastByte = !wide || second_reg;
  wire cycleEnd = busy_reg && lastByte &&
                  ((state_reg == ST_HOLD && cntDone) ||
                   (state_reg == ST_STROBE && fastOp && cntDone));

  always_comb begin
    addr_next = addr_reg;
    if (cycleEnd && incMode == PPC_INC_UP) begin
      addr_next = {addrUp[14], addr_reg[14], addrUp[13:0]};
    end else if (cycleEnd && incMode == PPC_INC_DOWN) begin
      addr_next = {addrDown[14], addr_reg[14], addrDown[13:0]};
    end
  end

  // sequence of one byte transfer
  always_comb begin
    state_next = state_reg;
    cntLoad    = 1'b0;
    cntValue   = PPC_TCY_CYC;
    case (state_reg)
      ST_IDLE: begin
        if (startXfer || (busy_reg && second_reg)) begin
          cntLoad = 1'b1;
          if (fastOp) begin
            state_next = ST_STROBE;
          end else if (muxSel == PPC_MUX_FULL || muxSel == PPC_MUX_LOW) begin
            state_next = ST_ADDR_LO;
            cntValue   = setupCyc;
          end else begin
            state_next = ST_SETUP;
            cntValue   = setupCyc;
          end
        end
      end
      ST_ADDR_LO: if (cntDone) begin
        cntLoad    = 1'b1;
        cntValue   = setupCyc;
        state_next = (muxSel == PPC_MUX_FULL) ? ST_ADDR_HI : ST_SETUP;
      end
      ST_ADDR_HI: if (cntDone) begin
        cntLoad    = 1'b1;
        cntValue   = setupCyc;
        state_next = ST_SETUP;
      end
      ST_SETUP: if (cntDone) begin
        cntLoad    = 1'b1;
        cntValue   = strobeCyc;
        state_next = ST_STROBE;
      end
      ST_STROBE: if (cntDone) begin
        cntLoad    = !fastOp;
        cntValue   = holdCyc;
        state_next = fastOp ? ST_IDLE : ST_HOLD;
      end
      ST_HOLD: if (cntDone) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!portOn) begin
      state_next = ST_IDLE;
      cntLoad    = 1'b0;
    end
  end

  // done falls in the last cycle, so phase lengths carry no extra clock
  ppc_wait_counter #(.W(5)) i_ppc_wait_counter (
    .clock (clock),
    .srst  (srst),
    .load  (cntLoad),
    .count (cntValue),
    .done  (cntDone)
  );

  // pin drive; active levels come from the polarity bits
  wire inLo   = state_reg == ST_ADDR_LO;
  wire inHi   = state_reg == ST_ADDR_HI;
  wire inStb  = state_reg == ST_STROBE;
  wire active = busy_reg && state_reg != ST_IDLE;
  wire sendHigh = wide && !second_reg;
  wire [7:0] curByte = sendHigh ? data_reg[15:8] : data_reg[7:0];
  wire latchPol = polar_reg[PPC_B_LATCH_POL];
  // latch pins double as address lines when not multiplexed
  wire latchUsed = muxSel != PPC_MUX_NONE;
  wire csLevel   = addr_reg[14] && active;
  wire beLevel   = sendHigh ? 1'b0 : 1'b1;
  wire m1        = mode == PPC_MODE_MASTER1;
  wire rdLevel   = m1 ? (active && isRead_reg) : (inStb && isRead_reg);
  wire wrLevel   = m1 ? inStb : (inStb && !isRead_reg);

  always_comb begin
    pins_next = '0;
    pins_next.readStrobe  = ~polar_reg[PPC_B_RD_POL];
    pins_next.writeStrobe = ~polar_reg[PPC_B_WR_POL];
    pins_next.latchLow    = ~latchPol;
    pins_next.latchHigh   = ~latchPol;
    pins_next.chipSelect  = ~polar_reg[PPC_B_CS_POL];
    pins_next.byteEnable  = ~polar_reg[PPC_B_BE_POL];
    if (portOn && isMaster) begin
      pins_next.addr = addr_reg[7:0];
      if (latchUsed) begin
        pins_next.latchLow  = inLo ~^ latchPol;
        pins_next.latchHigh = inHi ~^ latchPol;
      end else begin
        pins_next.latchLow  = addr_reg[0];
        pins_next.latchHigh = addr_reg[1];
      end
      if (csOn) begin
        pins_next.chipSelect = csLevel ~^ polar_reg[PPC_B_CS_POL];
      end else begin
        pins_next.chipSelect = addr_reg[14];
      end
      if (main_reg[PPC_B_BE_PIN]) begin
        pins_next.byteEnable = (active && beLevel) ~^ polar_reg[PPC_B_BE_POL];
      end
      if (main_reg[PPC_B_RD_PIN]) begin
        pins_next.readStrobe = rdLevel ~^ polar_reg[PPC_B_RD_POL];
      end
      if (main_reg[PPC_B_WR_PIN]) begin
        pins_next.writeStrobe = wrLevel ~^ polar_reg[PPC_B_WR_POL];
      end
      if (inLo) begin
        pins_next.dataOut = addr_reg[7:0];
        pins_next.dataOe  = 1'b1;
      end else if (inHi) begin
        pins_next.dataOut = addr_reg[15:8];
        pins_next.dataOe  = 1'b1;
      end else if (active && !isRead_reg && !inLo && !inHi) begin
        pins_next.dataOut = curByte;
        pins_next.dataOe  = 1'b1;
      end
    end
  end

  // slave modes: the external master owns the strobes
  wire slaveIrq = portOn && !isMaster && slaveAccess &&
                  irqMode == PPC_IRQ_BUFF3 &&
                  ((mode == PPC_MODE_ADDR_SLAVE && slaveAddr == 2'h3) ||
                   slaveBufThree);
  wire byteDone = busy_reg && (state_next == ST_IDLE) && state_reg != ST_IDLE;

  always_ff @(posedge clock) begin
    if (srst) begin
      timing_reg <= PPC_RST_REG;
      mode_reg   <= PPC_RST_REG;
      polar_reg  <= PPC_RST_REG;
      main_reg   <= PPC_RST_REG;
      addr_reg   <= 16'h0000;
      data_reg   <= 16'h0000;
      busy_reg   <= 1'b0;
      second_reg <= 1'b0;
      isRead_reg <= 1'b0;
      state_reg  <= ST_IDLE;
      pins       <= '0;
      regRdData  <= 8'h00;
      irqPulse   <= 1'b0;
      cpuStall   <= 1'b0;
    end else begin
      state_reg <= state_next;
      pins      <= pins_next;
      regRdData <= regRead ? rdMux : 8'h00;
      addr_reg  <= addr_next;
      if (cfgWrite && selTiming) timing_reg <= regWrData;
      if (cfgWrite && selMode)   mode_reg   <= {1'b0, regWrData[6:0]};
      if (cfgWrite && selPolar)  polar_reg  <= {regWrData[7:5], 1'b0,
                                                regWrData[3:0]};
      if (cfgWrite && selMain)   main_reg   <= {regWrData[7], 2'b00,
                                                regWrData[4:0]};
      if (cfgWrite && selAddrL)  addr_reg[7:0]  <= regWrData;
      if (cfgWrite && selAddrH)  addr_reg[15:8] <= regWrData;
      if (cfgWrite && selDataL)  data_reg[7:0]  <= regWrData;
      if (cfgWrite && selDataH)  data_reg[15:8] <= regWrData;
      // read data lands at the strobe's end
      if (inStb && isRead_reg && cntDone) begin
        if (sendHigh) data_reg[15:8] <= dataIn;
        else          data_reg[7:0]  <= dataIn;
      end
      if (startXfer) begin
        busy_reg   <= 1'b1;
        isRead_reg <= regRead;
        second_reg <= 1'b0;
      end else if (!portOn || cycleEnd) begin
        busy_reg   <= 1'b0;
        second_reg <= 1'b0;
      end else if (byteDone && wide) begin
        second_reg <= 1'b1;
      end
      irqPulse <= slaveIrq || (cycleEnd && irqMode == PPC_IRQ_END);
      cpuStall <= (startXfer || (busy_reg && !cycleEnd)) &&
                  irqMode == PPC_IRQ_STALL;
    end
  end

  chk_busy_off: assert property (@(posedge clock) disable iff (srst)
    !portOn |=> !busy_reg && state_reg == ST_IDLE)
    else $error("busy while port off");
  chk_busy_read: assert property (@(posedge clock) disable iff (srst)
    regRead && selMode |=> regRdData[PPC_B_BUSY] == $past(busy_reg))
    else $error("busy flag misread");
  chk_fast_skip: assert property (@(posedge clock) disable iff (srst)
    state_reg == ST_IDLE && startXfer && fastOp |=> state_reg == ST_STROBE)
    else $error("zero stretch did not skip setup");
  chk_no_irq: assert property (@(posedge clock) disable iff (srst)
    irqMode == 2'h0 && $past(irqMode) == 2'h0 |-> !irqPulse)
    else $error("interrupt in mode zero");
  chk_end_irq: assert property (@(posedge clock) disable iff (srst)
    cycleEnd && irqMode == PPC_IRQ_END |=> irqPulse)
    else $error("missing end interrupt");
  chk_inc_addr: assert property (@(posedge clock) disable iff (srst)
    cycleEnd && incMode == PPC_INC_UP && !regWrite |=>
    {addr_reg[15], addr_reg[13:0]} == $past(addrUp))
    else $error("address not incremented");
  chk_hold_addr: assert property (@(posedge clock) disable iff (srst)
    cycleEnd && incMode == 2'h0 && !regWrite |=> $stable(addr_reg))
    else $error("address moved in hold mode");
  chk_idle_cs: assert property (@(posedge clock) disable iff (srst)
    portOn && isMaster && csOn && !active |=>
    pins.chipSelect == ~$past(polar_reg[PPC_B_CS_POL]))
    else $error("chip select active when idle");
  sequence seqSetupDone;
    state_reg == ST_SETUP && cntDone;
  endsequence
  chk_setup_stb: assert property (@(posedge clock) disable iff (srst)
    seqSetupDone ##0 portOn |=> state_reg == ST_STROBE)
    else $error("strobe did not follow setup");
  chk_wide_two: assert property (@(posedge clock) disable iff (srst)
    byteDone && wide && !second_reg && portOn |=> busy_reg && second_reg)
    else $error("second byte missing");
  chk_fast_one: assert property (@(posedge clock) disable iff (srst)
    state_reg == ST_STROBE && fastOp |=> state_reg != ST_STROBE)
    else $error("zero stretch strobe longer than one cycle");
  chk_off_quiet: assert property (@(posedge clock) disable iff (srst)
    !portOn |=> !pins.dataOe && !cpuStall)
    else $error("port off but bus driven");
  chk_stall_on: assert property (@(posedge clock) disable iff (srst)
    busy_reg && !cycleEnd && irqMode == PPC_IRQ_STALL |=> cpuStall)
    else $error("processor not stalled during transfer");
  chk_cs_addr: assert property (@(posedge clock) disable iff (srst)
    portOn && isMaster && !csOn |=> pins.chipSelect == $past(addr_reg[14]))
    else $error("chip select pin not address bit 14");
endmodule // ppc_port_control

/* tb/ppc_peripheral.sv */
// Purpose: external parallel peripheral at the far side of the port
// Assumes: bench hands over one active-high data strobe and direction
// Notes: read words count up from 8'ha1, one per completed read strobe
`timescale 1ns/1ps
module ppc_peripheral
  import ppc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       strobe,
  input  wire logic       isRead,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output logic      [7:0] dataIn,
  output logic      [7:0] lastWrite
);
  logic [7:0] readWord;
  logic [7:0] noise;
  logic       strobeDly;
  initial begin
    readWord  = 8'ha1;
    noise     = 8'h5a;
    strobeDly = 1'b0;
    lastWrite = 8'h00;
  end
  // undriven bus flips every cycle so stale data never looks valid
  assign dataIn = (strobe && isRead) ? readWord : noise;
  always @(posedge clock) begin
    noise     <= ~noise;
    strobeDly <= strobe;
    if (strobeDly && !strobe && isRead) begin
      readWord <= readWord + 8'h01;
    end
    if (strobe && !isRead && dataOe) begin
      lastWrite <= dataOut;
    end
  end
endmodule // ppc_peripheral

/* tb/parallel_port_control_mode_tb.sv */
// Purpose: self-checking bench of the parallel port control block
// Assumes: one clock per instruction cycle, peripheral model on the pins
// Notes: transfers are watched while busy is polled by back-to-back reads
`timescale 1ns/1ps
module parallel_port_control_mode_tb
  import ppc_pkg::*;
  ;
  logic        clock;
  logic        srst;
  logic [11:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdData;
  logic [7:0]  dataIn;
  logic [7:0]  lastWrite;
  logic        slaveAccess;
  logic [1:0]  slaveAddr;
  logic        slaveBufThree;
  ppc_pins_t   pins;
  logic        irqPulse;
  logic        cpuStall;
  logic        useWr;
  logic        actHi;
  logic        isRead;
  logic [7:0]  v;
  logic [7:0]  latchLo;
  logic [7:0]  latchHi;
  logic [1:0]  beAt;
  int          fail_count;
  int          comparisons;
  int          stbCyc, stbPulses, firstStb, firstLatch;
  int          stallCyc, irqCnt, busyCyc, holdCyc;
  wire logic   stbAct = ((useWr ? pins.writeStrobe : pins.readStrobe)
                         === actHi);

  ppc_port_control i_ppc_port_control (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .dataIn(dataIn), .slaveAccess(slaveAccess), .slaveAddr(slaveAddr),
    .slaveBufThree(slaveBufThree), .pins(pins), .irqPulse(irqPulse),
    .cpuStall(cpuStall));
  ppc_peripheral i_ppc_peripheral (
    .clock(clock), .strobe(stbAct), .isRead(isRead),
    .dataOut(pins.dataOut), .dataOe(pins.dataOe), .dataIn(dataIn),
    .lastWrite(lastWrite));

  always #50 clock = ~clock;

  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkCnt(input string n, input int lo, hi, g);
    comparisons++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic strobe(input logic [11:0] a, logic [7:0] d, bit w);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    if (w) regWrite <= 1'b1;
    else regRead <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    strobe(a, d, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    strobe(a, 8'h00, 1'b0);
    @(negedge clock);
    d = regRdData;
  endtask
  task automatic cfg(input logic [7:0] tm, md, pl, mn);
    wr(PPC_OFS_TIMING, tm);
    wr(PPC_OFS_MODE, md);
    wr(PPC_OFS_POLAR, pl);
    wr(PPC_OFS_MAIN, mn);
  endtask
  task automatic setPol(input logic [7:0] pl);
    wr(PPC_OFS_POLAR, pl);
    repeat (3) @(negedge clock);
  endtask
  // busy lags the pins by a read, so three idle samples end the watch
  task automatic watch();
    int i;
    int idle;
    logic prev;
    {stbCyc, stbPulses, stallCyc, irqCnt, busyCyc, holdCyc} = '0;
    firstStb = 999;
    firstLatch = 999;
    idle = 0;
    prev = 1'b0;
    @(posedge clock);
    regAddr <= PPC_OFS_MODE;
    regRead <= 1'b1;
    for (i = 0; i < 300 && idle < 3; i++) begin
      @(negedge clock);
      if (stbAct && firstStb > i) firstStb = i;
      if (stbAct) stbCyc++;
      if (stbAct && !prev && stbPulses < 2) beAt[stbPulses] = pins.byteEnable;
      if (stbAct && !prev) stbPulses++;
      if (!stbAct && stbPulses > 0 && regRdData[7] === 1'b1) holdCyc++;
      if (pins.latchLow === 1'b1 && firstLatch > i) latchLo = pins.dataOut;
      if (pins.latchLow === 1'b1 && firstLatch > i) firstLatch = i;
      if (pins.latchHigh === 1'b1) latchHi = pins.dataOut;
      if (cpuStall === 1'b1) stallCyc++;
      if (irqPulse === 1'b1) irqCnt++;
      if (regRdData[7] === 1'b1) busyCyc++;
      idle = (i > 1 && regRdData[7] === 1'b0) ? idle + 1 : 0;
      prev = stbAct;
    end
    chkCnt("busyEnds", 3, 3, idle);
    @(posedge clock);
    regRead <= 1'b0;
  endtask

  task automatic t_regs();
    logic [11:0] ofs [4] = '{PPC_OFS_TIMING, PPC_OFS_MODE, PPC_OFS_POLAR,
                             PPC_OFS_MAIN};
    logic [7:0] msk [4] = '{8'hff, 8'h7f, 8'hef, 8'h9f};
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], v);
      chk("resetValue", PPC_RST_REG, v);
    end
    rd(12'hf50, v);
    chk("unmapped", 8'h00, v);
    for (int k = 0; k < 4; k++) begin
      wr(ofs[k], 8'hff);
      rd(ofs[k], v);
      chk("accessMask", msk[k], v);
    end
    for (int k = 3; k >= 0; k--) wr(ofs[k], 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pins();
    cfg(8'h00, 8'h02, 8'h00, 8'h83);
    wr(PPC_OFS_ADDRL, 8'h01);
    wr(PPC_OFS_ADDRH, 8'h40);
    setPol(8'h00);
    chk("rdIdleLowPol", 1'b1, pins.readStrobe);
    chk("wrIdleLowPol", 1'b1, pins.writeStrobe);
    chk("csAsAddr14", 1'b1, pins.chipSelect);
    setPol(8'h2b);
    chk("rdIdleHighPol", 1'b0, pins.readStrobe);
    chk("wrIdleHighPol", 1'b0, pins.writeStrobe);
    chk("latchAsAddr0", 1'b1, pins.latchLow);
    chk("latchAsAddr1", 1'b0, pins.latchHigh);
    chk("csPolIgnored", 1'b1, pins.chipSelect);
    setPol(8'h88);
    chk("csIdleHighPol", 1'b0, pins.chipSelect);
    setPol(8'h80);
    chk("csIdleLowPol", 1'b1, pins.chipSelect);
    wr(PPC_OFS_MAIN, 8'h93);
    setPol(8'h20);
    chk("latchIdleHiPol", 2'b00, {pins.latchLow, pins.latchHigh});
    setPol(8'h00);
    chk("latchIdleLoPol", 2'b11, {pins.latchLow, pins.latchHigh});
    $display("test pins done");
  endtask
  task automatic t_off();
    cfg(8'h08, 8'h02, 8'h03, 8'h03);
    useWr = 1'b1;
    isRead = 1'b0;
    wr(PPC_OFS_DATAL, 8'h77);
    watch();
    chkCnt("offStrobe", 0, 0, stbCyc);
    chkCnt("offBusy", 0, 0, busyCyc);
    $display("test off done");
  endtask
  task automatic t_write8();
    cfg(8'h4a, 8'h2a, 8'h23, 8'h97);
    wr(PPC_OFS_ADDRL, 8'h5a);
    wr(PPC_OFS_ADDRH, 8'h12);
    wr(PPC_OFS_DATAL, 8'h3c);
    watch();
    chkCnt("strobeWidth", 3, 3, stbCyc);
    chkCnt("pulses8", 1, 1, stbPulses);
    chk("muxAddrLow", 8'h5a, latchLo);
    chk("muxAddrHigh", 8'h12, latchHi);
    chkCnt("latchBeforeStb", 0, firstStb - 3, firstLatch);
    chkCnt("holdAfterStb", 3, 3, holdCyc);
    chk("wrData", 8'h3c, lastWrite);
    chkCnt("irqEndCycle", 1, 1, irqCnt);
    rd(PPC_OFS_ADDRL, v);
    chk("addrIncrement", 8'h5b, v);
    $display("test write8 done");
  endtask
  task automatic t_strobe0();
    int firstBusy;
    cfg(8'hc3, 8'h12, 8'h03, 8'h83);
    wr(PPC_OFS_ADDRL, 8'h10);
    wr(PPC_OFS_ADDRH, 8'h00);
    wr(PPC_OFS_DATAL, 8'h81);
    watch();
    firstBusy = busyCyc;
    chkCnt("oneCycleStb", 1, 1, stbCyc);
    chkCnt("noIrq", 0, 0, irqCnt);
    wr(PPC_OFS_TIMING, 8'h00);
    wr(PPC_OFS_DATAL, 8'h82);
    watch();
    chkCnt("waitsIgnored", firstBusy, firstBusy, busyCyc);
    chk("wrData0", 8'h82, lastWrite);
    rd(PPC_OFS_ADDRL, v);
    chk("addrDecrement", 8'h0e, v);
    $display("test strobe0 done");
  endtask
  task automatic t_read16();
    cfg(8'h04, 8'h47, 8'h07, 8'h87);
    wr(PPC_OFS_ADDRL, 8'h40);
    isRead = 1'b1;
    strobe(PPC_OFS_DATAH, 8'h00, 1'b0);
    watch();
    chkCnt("pulses16", 2, 2, stbPulses);
    chkCnt("enableWidth", 4, 4, stbCyc);
    chk("byteEnOrder", 2'b10, beAt);
    chkCnt("stall", 1, 300, stallCyc);
    chkCnt("noIrqStall", 0, 0, irqCnt);
    // port off first, else reading the data word starts another transfer
    wr(PPC_OFS_MAIN, 8'h07);
    rd(PPC_OFS_DATAH, v);
    chk("highFirst", 8'ha1, v);
    rd(PPC_OFS_DATAL, v);
    chk("lowSecond", 8'ha2, v);
    rd(PPC_OFS_ADDRL, v);
    chk("addrHold", 8'h40, v);
    $display("test read16 done");
  endtask
  task automatic slavePulse(input logic [1:0] a, input logic b3, input int e);
    int n;
    n = 0;
    @(posedge clock);
    slaveAccess   <= 1'b1;
    slaveAddr     <= a;
    slaveBufThree <= b3;
    @(posedge clock);
    slaveAccess <= 1'b0;
    repeat (4) begin
      @(negedge clock);
      if (irqPulse === 1'b1) n++;
    end
    chkCnt("slaveIrq", e, e, n);
  endtask
  task automatic t_slave();
    cfg(8'h00, 8'h61, 8'h00, 8'h80);
    slavePulse(2'b11, 1'b0, 1);
    slavePulse(2'b01, 1'b0, 0);
    wr(PPC_OFS_MODE, 8'h60);
    slavePulse(2'b00, 1'b1, 1);
    $display("test slave done");
  endtask

  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    {regAddr, regWrData, regWrite, regRead} = '0;
    {slaveAccess, slaveAddr, slaveBufThree} = '0;
    {useWr, isRead, actHi} = 3'b001;
    {fail_count, comparisons} = '0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_pins();
    t_off();
    t_write8();
    t_strobe0();
    t_read16();
    t_slave();
    results();
  end
  // whole run is near 250 cycles, so 20000 means a hang
  initial begin
    #2000000;
    fail_count++;
    results();
  end
endmodule // parallel_port_control_mode_tb
